//--- hw/rss_reset_select.sv
// Reset source selection with Wishbone configuration and status registers
`default_nettype none

// Operation
// - 16-bit config register; bits 1,4,5 read one, bits 6 to 15 read zero.
// - Config bit 0 set: unrecoverable CPU failure resets the backplane.
// - Config bit 2 set: front-panel reset input resets the backplane.
// - Config bit 3 set: front-panel reset input resets the processor.
// - A cleared config bit disables its reset condition completely.
// - Several enabled conditions combine as a logical OR per reset output.
module rss_reset_select
    import rss_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire rss_wb_req_t wb_req_i,
    output var rss_wb_rsp_t wb_rsp_o,
    input wire logic front_panel_reset_i,
    input wire logic cpu_failure_i,
    output logic backplane_reset_o,
    output logic cpu_reset_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] in_raw;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic fp_s;
    logic fail_s;

    assign in_raw = {cpu_failure_i, front_panel_reset_i};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= in_raw[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    assign fp_s = sync2_q[0];
    assign fail_s = sync2_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic req;
    logic ack_q;
    logic [31:0] dat_q;
    logic hit_cfg;
    logic hit_stat;
    logic wr_now;

    assign req = wb_req_i.cyc & wb_req_i.stb;
    assign hit_cfg = wb_req_i.adr[31:2] == RSS_CFG_OFF[31:2];
    assign hit_stat = wb_req_i.adr[31:2] == RSS_STAT_OFF[31:2];
    // Write lands on the edge at which the master samples ack
    assign wr_now = req & ack_q & wb_req_i.we;

    ////////////////////////////////////////////////////////////////////////
    // Configuration register

    logic [15:0] cfg_q;
    logic [15:0] cfg_rd;

    // Only the selectable bits are stored; fixed bits are pure constants
    assign cfg_rd = (cfg_q & RSS_CFG_WMASK) | RSS_CFG_FIXED;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cfg_q <= RSS_CFG_RST;
        end else if (wr_now && hit_cfg && wb_req_i.sel[0]) begin
            cfg_q <= wb_req_i.dat[15:0] & RSS_CFG_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset generation

    logic bp_q;
    logic cpu_q;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bp_q <= 1'b0;
            cpu_q <= 1'b0;
        end else begin
            // Registered so a config write never glitches the outputs
            bp_q <= (fail_s & cfg_q[RSS_BIT_FAIL_BP])
                | (fp_s & cfg_q[RSS_BIT_FP_BP]);
            cpu_q <= fp_s & cfg_q[RSS_BIT_FP_CPU];
        end
    end

    assign backplane_reset_o = bp_q;
    assign cpu_reset_o = cpu_q;

    ////////////////////////////////////////////////////////////////////////
    // Sticky event flags, write one to clear, set wins

    logic bp_seen_q;
    logic cpu_seen_q;
    logic clr_ok;

    assign clr_ok = wr_now & hit_stat & wb_req_i.sel[1];

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bp_seen_q <= 1'b0;
            cpu_seen_q <= 1'b0;
        end else begin
            bp_seen_q <= bp_q
                | (bp_seen_q & ~(clr_ok & wb_req_i.dat[RSS_ST_BP_SEEN]));
            cpu_seen_q <= cpu_q
                | (cpu_seen_q & ~(clr_ok & wb_req_i.dat[RSS_ST_CPU_SEEN]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer

    logic [31:0] stat_rd;

    always_comb begin
        stat_rd = RSS_DAT_ZERO;
        stat_rd[RSS_ST_FP] = fp_s;
        stat_rd[RSS_ST_FAIL] = fail_s;
        stat_rd[RSS_ST_BP_OUT] = bp_q;
        stat_rd[RSS_ST_CPU_OUT] = cpu_q;
        stat_rd[RSS_ST_BP_SEEN] = bp_seen_q;
        stat_rd[RSS_ST_CPU_SEEN] = cpu_seen_q;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Unmapped addresses still ack and read zero, so the master never hangs
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dat_q <= RSS_DAT_ZERO;
        end else if (req && !ack_q) begin
            if (hit_cfg) begin
                dat_q <= {16'h0000, cfg_rd};
            end else if (hit_stat) begin
                dat_q <= stat_rd;
            end else begin
                dat_q <= RSS_DAT_ZERO;
            end
        end
    end

    assign wb_rsp_o = '{ack: ack_q, dat: dat_q};

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_cfg_fixed;
        @(posedge core_clk_i) disable iff (reset_i)
        (ack_q && !wb_req_i.we && hit_cfg)
            |-> (dat_q[31:6] == 26'h0 && dat_q[5:4] == 2'b11 && dat_q[1]);
    endproperty
    a_cfg_fixed: assert property (p_cfg_fixed)
        else $error("config read shows wrong fixed bits");

    property p_fail_bp;
        @(posedge core_clk_i) disable iff (reset_i)
        (cpu_failure_i && cfg_q[RSS_BIT_FAIL_BP])[*3] |=> backplane_reset_o;
    endproperty
    a_fail_bp: assert property (p_fail_bp)
        else $error("processor failure did not reset backplane");

    property p_fp_bp;
        @(posedge core_clk_i) disable iff (reset_i)
        (front_panel_reset_i && cfg_q[RSS_BIT_FP_BP])[*3]
            |=> backplane_reset_o;
    endproperty
    a_fp_bp: assert property (p_fp_bp)
        else $error("front panel did not reset backplane");

    property p_fp_cpu;
        @(posedge core_clk_i) disable iff (reset_i)
        (front_panel_reset_i && cfg_q[RSS_BIT_FP_CPU])[*3] |=> cpu_reset_o;
    endproperty
    a_fp_cpu: assert property (p_fp_cpu)
        else $error("front panel did not reset processor");

    property p_cpu_off;
        @(posedge core_clk_i) disable iff (reset_i)
        !cfg_q[RSS_BIT_FP_CPU] |=> !cpu_reset_o;
    endproperty
    a_cpu_off: assert property (p_cpu_off)
        else $error("processor reset while disabled");

    property p_bp_off;
        @(posedge core_clk_i) disable iff (reset_i)
        !(fail_s && cfg_q[RSS_BIT_FAIL_BP]) && !(fp_s && cfg_q[RSS_BIT_FP_BP])
            |=> !backplane_reset_o;
    endproperty
    a_bp_off: assert property (p_bp_off)
        else $error("backplane reset with no enabled cause");

    property p_bp_or;
        @(posedge core_clk_i) disable iff (reset_i)
        (fail_s && cfg_q[RSS_BIT_FAIL_BP]) || (fp_s && cfg_q[RSS_BIT_FP_BP])
            |=> backplane_reset_o;
    endproperty
    a_bp_or: assert property (p_bp_or)
        else $error("enabled cause did not reset backplane");

    property p_sync_lat;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(fp_s) |-> $past(sync1_q[0]) && $past(front_panel_reset_i, 2);
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("front panel bypassed the synchroniser");

    property p_ack_pulse;
        @(posedge core_clk_i) disable iff (reset_i)
        ack_q |=> !ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_fail_sync;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(fail_s) |-> $past(sync1_q[1]) && $past(cpu_failure_i, 2);
    endproperty
    a_fail_sync: assert property (p_fail_sync)
        else $error("processor failure bypassed the synchroniser");

    property p_fp_cpu_on;
        @(posedge core_clk_i) disable iff (reset_i)
        fp_s && cfg_q[RSS_BIT_FP_CPU] |=> cpu_reset_o;
    endproperty
    a_fp_cpu_on: assert property (p_fp_cpu_on)
        else $error("enabled front panel reset missed the processor");

    property p_cpu_fp_only;
        @(posedge core_clk_i) disable iff (reset_i)
        !fp_s |=> !cpu_reset_o;
    endproperty
    a_cpu_fp_only: assert property (p_cpu_fp_only)
        else $error("processor reset without front panel cause");

    property p_ack_answer;
        @(posedge core_clk_i) disable iff (reset_i)
        req && !ack_q |=> ack_q;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not acked in the next cycle");

    property p_cfg_write;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_now && hit_cfg && wb_req_i.sel[0]
            |=> cfg_q == ($past(wb_req_i.dat[15:0]) & RSS_CFG_WMASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config write did not land");

    property p_seen_bp;
        @(posedge core_clk_i) disable iff (reset_i)
        bp_q |=> bp_seen_q;
    endproperty
    a_seen_bp: assert property (p_seen_bp)
        else $error("backplane reset event not recorded");

    property p_seen_cpu;
        @(posedge core_clk_i) disable iff (reset_i)
        cpu_q |=> cpu_seen_q;
    endproperty
    a_seen_cpu: assert property (p_seen_cpu)
        else $error("processor reset event not recorded");

    // Backplane flag clear only takes when no backplane reset is active in the same cycle
    property p_seen_clr;
        @(posedge core_clk_i) disable iff (reset_i)
        clr_ok && wb_req_i.dat[RSS_ST_BP_SEEN] && !bp_q
            |=> !bp_seen_q;
    endproperty
    a_seen_clr: assert property (p_seen_clr)
        else $error("backplane event flag not cleared");

    property p_rst_quiet;
        @(posedge core_clk_i)
        reset_i |=> !backplane_reset_o && !cpu_reset_o && !wb_rsp_o.ack;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active after reset");

    c_fp_both: cover property (@(posedge core_clk_i) disable iff (reset_i)
        backplane_reset_o && cpu_reset_o);
    c_fail_only: cover property (@(posedge core_clk_i) disable iff (reset_i)
        backplane_reset_o && fail_s && !fp_s);
    c_fp_masked: cover property (@(posedge core_clk_i) disable iff (reset_i)
        fp_s && !cfg_q[RSS_BIT_FP_CPU] && !cpu_reset_o);
    c_cfg_write: cover property (@(posedge core_clk_i) disable iff (reset_i)
        wr_now && hit_cfg);
    c_seen_clr: cover property (@(posedge core_clk_i) disable iff (reset_i)
        clr_ok && bp_seen_q && !bp_q);

endmodule
`default_nettype wire

//--- pkg/rss_pkg.sv
// Package for the reset source selection block: map, fields, bus carriers
`default_nettype none
package rss_pkg;

    // Register byte addresses
    localparam logic [31:0] RSS_CFG_OFF = 32'h0000_0000;
    localparam logic [31:0] RSS_STAT_OFF = 32'h0000_0004;

    // Configuration register layout
    localparam int RSS_CFG_W = 16;
    localparam int RSS_BIT_FAIL_BP = 0;
    localparam int RSS_BIT_FP_BP = 2;
    localparam int RSS_BIT_FP_CPU = 3;
    localparam logic [15:0] RSS_CFG_FIXED = 16'h0032;
    localparam logic [15:0] RSS_CFG_WMASK = 16'h000d;
    localparam logic [15:0] RSS_CFG_RST = 16'h0000;

    // Status register layout
    localparam int RSS_ST_FP = 0;
    localparam int RSS_ST_FAIL = 1;
    localparam int RSS_ST_BP_OUT = 2;
    localparam int RSS_ST_CPU_OUT = 3;
    localparam int RSS_ST_BP_SEEN = 8;
    localparam int RSS_ST_CPU_SEEN = 9;

    localparam logic [31:0] RSS_DAT_ZERO = 32'h0000_0000;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rss_wb_req_t;

    // Classic Wishbone answer from this slave
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rss_wb_rsp_t;

endpackage
`default_nettype wire

//--- sim/rss_fp_src.sv
// Model of the front-panel reset source and processor failure line
`default_nettype none
module rss_fp_src (
    input wire logic core_clk_i,
    input wire logic press_i,
    input wire logic fail_i,
    output logic front_panel_reset_o,
    output logic cpu_failure_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels move only after an edge, like a debounced button
    always_ff @(posedge core_clk_i) begin
        front_panel_reset_o <= press_i;
        cpu_failure_o <= fail_i;
    end
endmodule
`default_nettype wire

//--- sim/rss_reset_select_tb.sv
// Self-checking bench for the reset source selection block
`default_nettype none
module rss_reset_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rss_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic press = 1'b0;
    logic fail = 1'b0;
    rss_wb_req_t req = '0;
    rss_wb_rsp_t rsp;
    logic fp, cf, bp_o, cpu_o;
    int num_errors = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    logic [31:0] seed = 32'd94123;
    logic [31:0] r, v;
    logic [15:0] c;
    logic b, u;
    localparam logic [31:0] SEEN_BITS =
        (32'h1 << RSS_ST_BP_SEEN) | (32'h1 << RSS_ST_CPU_SEEN);
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    rss_fp_src rss_fp_src_inst (
        .core_clk_i(core_clk_i),
        .press_i(press),
        .fail_i(fail),
        .front_panel_reset_o(fp),
        .cpu_failure_o(cf)
    );
    rss_reset_select rss_reset_select_inst (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wb_req_i(req),
        .wb_rsp_o(rsp),
        .front_panel_reset_i(fp),
        .cpu_failure_i(cf),
        .backplane_reset_o(bp_o),
        .cpu_reset_o(cpu_o)
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] exp_cfg(input logic [31:0] d);
        return {16'h0000, (d[15:0] & RSS_CFG_WMASK) | RSS_CFG_FIXED};
    endfunction
    function automatic logic [31:0] exp_stat(input logic p, input logic f,
                                             input logic bo, input logic uo);
        logic [31:0] s;
        s = RSS_DAT_ZERO;
        s[RSS_ST_FP] = p;
        s[RSS_ST_FAIL] = f;
        s[RSS_ST_BP_OUT] = bo;
        s[RSS_ST_CPU_OUT] = uo;
        s[RSS_ST_BP_SEEN] = bo;
        s[RSS_ST_CPU_SEEN] = uo;
        return s;
    endfunction
    task automatic results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Held until ack is seen; no answer latency is assumed
    task automatic wb(input logic we, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do @(posedge core_clk_i); while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        wb(1'b0, RSS_CFG_OFF, 32'h0, r);
        chk(r, 32'h0000_0032);
        wb(1'b0, 32'h0000_0010, 32'h0, r);
        chk(r, 32'h0);
        // First sixteen passes walk every selectable combination
        for (int i = 0; i < 48; i++) begin
            v = (i < 16) ? i : xs();
            c = v[15:0] & RSS_CFG_WMASK;
            wb(1'b1, RSS_CFG_OFF, v, r);
            wb(1'b0, RSS_CFG_OFF, 32'h0, r);
            chk(r, exp_cfg(v));
            v = xs();
            press <= v[0];
            fail <= v[1];
            b = (v[1] & c[RSS_BIT_FAIL_BP]) | (v[0] & c[RSS_BIT_FP_BP]);
            u = v[0] & c[RSS_BIT_FP_CPU];
            // Model flop plus two sync stages plus output flop
            repeat (6) @(posedge core_clk_i);
            chk(bp_o, b);
            chk(cpu_o, u);
            // Clear both flags; a reset still active sets them again
            wb(1'b1, RSS_STAT_OFF, SEEN_BITS, r);
            wb(1'b0, RSS_STAT_OFF, 32'h0, r);
            chk(r, exp_stat(v[0], v[1], b, u));
        end
        // Mid-run reset with both inputs held high
        press <= 1'b1;
        fail <= 1'b1;
        reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk({bp_o, cpu_o, rsp.ack}, 32'h0);
        reset_i <= 1'b0;
        wb(1'b0, RSS_CFG_OFF, 32'h0, r);
        chk(r, exp_cfg(32'h0));
        repeat (6) @(posedge core_clk_i);
        chk({bp_o, cpu_o}, 32'h0);
        wb(1'b0, RSS_STAT_OFF, 32'h0, r);
        chk(r, exp_stat(1'b1, 1'b1, 1'b0, 1'b0));
        results();
    end
endmodule
`default_nettype wire
